// ### sfp_frame_parser.sv
`timescale 1ns/100ps

module sfp_frame_parser (
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  input  wire logic                       in_valid,
  input  wire logic                       in_bit,
  input  wire logic                       in_last,
  input  wire logic                       channel_aware_mode,
  output logic                            frame_valid,
  output logic                            frame_error,
  output sfp_pkg::sfp_rate_e              frame_rate,
  output logic [sfp_pkg::SFP_CNT_W-1:0]   frame_length,
  output sfp_pkg::sfp_core_e              core_select,
  output logic [3:0]                      coder_type_index,
  output logic [1:0]                      transform_excitation_type,
  output logic                            hq_prev_lp,
  output logic                            hq_rate_16k,
  output logic                            sid_is_lp,
  output logic [1:0]                      audio_bandwidth_index,
  output logic                            sid_rate_16k,
  output logic [6:0]                      sid_gain,
  output logic [36:0]                     sid_band_energy,
  output logic [2:0]                      sid_hangover,
  output logic [28:0]                     sid_spectral_pairs,
  output logic [6:0]                      sid_lowband_energy,
  output logic [5:0]                      sid_envelope,
  output logic [3:0]                      sid_highband_energy,
  output logic [4:0]                      ca_header,
  output logic                            redundant_copy_flag,
  output logic [2:0]                      ca_offset,
  output sfp_pkg::sfp_redundant_e         ca_type,
  output logic                            ca_partial_present
);
  import sfp_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    sfp_rate_e          rate;
    logic [SFP_CNT_W-1:0] length;
    sfp_core_e          core;
    logic [3:0]         cidx;
    logic [1:0]         tcx_type;
    logic               hq_prev;
    logic               hq_rate;
    logic               sid_lp;
    logic [1:0]         bw;
    logic               sid_rate;
    logic [6:0]         gain;
    logic [36:0]        energy;
    logic [2:0]         hang;
    logic [28:0]        lsf;
    logic [6:0]         low;
    logic [5:0]         env;
    logic [3:0]         hb;
    logic [4:0]         hdr;
    logic               rf;
    logic [2:0]         offset;
    sfp_redundant_e     rtype;
    logic               partial;
  } sfp_fields_s;

  typedef struct packed {
    logic [SFP_CNT_W-1:0]  cnt;
    logic [SFP_HEAD_W-1:0] head;
    logic [SFP_TAIL_W-1:0] tail;
    logic                  valid;
    logic                  error;
    sfp_fields_s           f;
  } sfp_state_s;

  sfp_state_s st_reg;
  sfp_state_s st_next;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Pulls a field of up to 37 bits out of the captured frame head.
  function automatic logic [36:0] fld(input logic [SFP_HEAD_W-1:0] h,
                                      input int pos,
                                      input int w);
    logic [SFP_HEAD_W-1:0] s;
    logic [36:0]           m;
    // At width 37 the shift wraps to zero, so the mask becomes all ones
    s   = h >> (SFP_HEAD_W - pos - w);
    m   = (37'h1 << w) - 37'h1;
    fld = s[36:0] & m;
  endfunction

  // Frame bit pos of the captured head; bit 0 arrived first
  function automatic logic head_bit(input logic [SFP_HEAD_W-1:0] h,
                                    input int pos);
    head_bit = h[SFP_HEAD_W-1-pos];
  endfunction

  // Offset codes 0..3 map onto the four allowed frame distances
  function automatic logic [2:0] offset_map(input logic [1:0] code);
    logic [2:0] v;
    v = CA_OFFSET_0;
    case (code)
      2'h0:    v = CA_OFFSET_0;
      2'h1:    v = CA_OFFSET_1;
      2'h2:    v = CA_OFFSET_2;
      2'h3:    v = CA_OFFSET_3;
      default: v = CA_OFFSET_0;
    endcase
    return v;
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic [SFP_HEAD_W-1:0] h;
    logic [SFP_TAIL_W-1:0] t;
    logic [SFP_CNT_W-1:0]  len;
    logic                  known;
    h     = st_reg.head;
    t     = {st_reg.tail[SFP_TAIL_W-2:0], in_bit};
    len   = st_reg.cnt;
    known = 1'b0;
    st_next       = st_reg;
    st_next.valid = 1'b0;
    st_next.error = 1'b0;
    if (in_valid) begin
      // Only the first 48 bits are kept; later bits only feed the tail
      if (st_reg.cnt < SFP_LEN_SID) begin
        h = {st_reg.head[SFP_HEAD_W-2:0], in_bit};
      end
      st_next.head = h;
      // Tail keeps the last five bits for the redundant-copy trailer
      st_next.tail = t;
      // Saturate so an endless frame cannot wrap onto a known length
      if (st_reg.cnt != SFP_LEN_MAX) begin
        len = st_reg.cnt + 12'h001;
      end
      st_next.cnt = len;
      if (in_last) begin
        st_next.cnt      = '0;
        st_next.head     = '0;
        st_next.tail     = '0;
        st_next.f        = '0;
        st_next.f.length = len;
        known            = 1'b1;
        // Channel-aware mode accepts only the one frame length
        if (channel_aware_mode && (len != SFP_LEN_13K2)) begin
          known = 1'b0;
        end else if (len == SFP_LEN_SID) begin
          st_next.f.rate   = SFP_RATE_SID;
          st_next.f.sid_lp = head_bit(h, SID_TYPE_POS);
          if (!head_bit(h, SID_TYPE_POS)) begin
            st_next.f.bw       = 2'(fld(h, FD_BW_POS, FD_BW_W));
            st_next.f.sid_rate = h[SFP_HEAD_W-1-FD_RATE_POS];
            st_next.f.gain     = 7'(fld(h, FD_GAIN_POS, FD_GAIN_W));
            st_next.f.energy   = fld(h, FD_ENERGY_POS, FD_ENERGY_W);
          end else begin
            st_next.f.bw       = {1'b0, h[SFP_HEAD_W-1-LP_BW_POS]};
            st_next.f.sid_rate = h[SFP_HEAD_W-1-LP_RATE_POS];
            st_next.f.hang     = 3'(fld(h, LP_HANG_POS, LP_HANG_W));
            st_next.f.lsf      = 29'(fld(h, LP_LSF_POS, LP_LSF_W));
            st_next.f.low      = 7'(fld(h, LP_LOW_POS, LP_LOW_W));
            if (!h[SFP_HEAD_W-1-LP_BW_POS]) begin
              st_next.f.env = 6'(fld(h, LP_ENV_POS, LP_ENV_W));
            end else begin
              st_next.f.hb  = 4'(fld(h, LP_HB_POS, LP_HB_W));
            end
          end
        end else if (len == SFP_LEN_13K2) begin
          st_next.f.hdr = 5'(fld(h, CA_HDR_POS, CA_HDR_W));
          st_next.f.rf  = channel_aware_mode &&
                          head_bit(h, CA_HDR_POS+CA_HDR_W-1-CA_RF_BIT);
          st_next.f.rate = SFP_RATE_13K2;
          // A cleared flag leaves the frame as a plain 13.2k one
          if (st_next.f.rf) begin
            st_next.f.rate    = SFP_RATE_CA;
            st_next.f.offset  = offset_map(t[4:3]);
            st_next.f.rtype   = sfp_redundant_e'(t[2:0]);
            // Primary kind is not checked against partial kind
            st_next.f.partial = (t[2:0] != REDUNDANT_TYPE_EMPTY);
          end
        end else if (len == SFP_LEN_32K) begin
          st_next.f.rate = SFP_RATE_32K;
          if (!h[SFP_HEAD_W-1-CORE_FLAG_POS]) begin
            st_next.f.core = SFP_CORE_LP;
            st_next.f.cidx = 4'(fld(h, CIDX_POS, CIDX_W));
          end else if (h[SFP_HEAD_W-1-MDCT_SEL_POS]) begin
            st_next.f.core     = SFP_CORE_TCX;
            st_next.f.tcx_type = 2'(fld(h, TCX_TYPE_POS, TCX_TYPE_W));
          end else begin
            st_next.f.core    = SFP_CORE_HQ;
            st_next.f.hq_prev = h[SFP_HEAD_W-1-HQ32_PREV_POS];
            st_next.f.hq_rate = h[SFP_HEAD_W-1-HQ32_PREV_POS] &&
                                h[SFP_HEAD_W-1-HQ32_RATE_POS];
          end
        end else if (len == SFP_LEN_48K) begin
          st_next.f.rate = SFP_RATE_48K;
          st_next.f.core = SFP_CORE_TCX;
        end else if (len == SFP_LEN_64K) begin
          st_next.f.rate = SFP_RATE_64K;
          if (!h[SFP_HEAD_W-1-CORE_FLAG_POS]) begin
            st_next.f.core = SFP_CORE_LP;
            st_next.f.cidx = 4'(fld(h, CIDX_POS, CIDX_W));
          end else begin
            st_next.f.core    = SFP_CORE_HQ;
            st_next.f.hq_prev = h[SFP_HEAD_W-1-HQ64_PREV_POS];
            st_next.f.hq_rate = h[SFP_HEAD_W-1-HQ64_PREV_POS] &&
                                h[SFP_HEAD_W-1-HQ64_RATE_POS];
          end
        end else begin
          known = 1'b0;
        end
        // Unknown lengths leave only the length visible
        if (!known) begin
          st_next.f        = '0;
          st_next.f.length = len;
        end
        st_next.valid = known;
        st_next.error = !known;
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Reset loads constants only, so every output reads zero until a frame
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Strobes last one cycle; fields hold until the next frame end
  assign frame_valid               = st_reg.valid;
  assign frame_error               = st_reg.error;
  assign frame_rate                = st_reg.f.rate;
  assign frame_length              = st_reg.f.length;
  assign core_select               = st_reg.f.core;
  assign coder_type_index          = st_reg.f.cidx;
  assign transform_excitation_type = st_reg.f.tcx_type;
  assign hq_prev_lp                = st_reg.f.hq_prev;
  assign hq_rate_16k               = st_reg.f.hq_rate;
  assign sid_is_lp                 = st_reg.f.sid_lp;
  assign audio_bandwidth_index     = st_reg.f.bw;
  assign sid_rate_16k              = st_reg.f.sid_rate;
  assign sid_gain                  = st_reg.f.gain;
  assign sid_band_energy           = st_reg.f.energy;
  assign sid_hangover              = st_reg.f.hang;
  assign sid_spectral_pairs        = st_reg.f.lsf;
  assign sid_lowband_energy        = st_reg.f.low;
  assign sid_envelope              = st_reg.f.env;
  assign sid_highband_energy       = st_reg.f.hb;
  assign ca_header                 = st_reg.f.hdr;
  assign redundant_copy_flag       = st_reg.f.rf;
  assign ca_offset                 = st_reg.f.offset;
  assign ca_type                   = st_reg.f.rtype;
  assign ca_partial_present        = st_reg.f.partial;

endmodule // sfp_frame_parser

// ### sfp_pkg.sv
package sfp_pkg;

  // ****************************************************************
  // Frame geometry
  // ****************************************************************
  localparam int SFP_HEAD_W = 48;
  localparam int SFP_TAIL_W = 5;
  localparam int SFP_CNT_W  = 12;

  localparam logic [SFP_CNT_W-1:0] SFP_LEN_SID  = 12'h030;
  localparam logic [SFP_CNT_W-1:0] SFP_LEN_13K2 = 12'h108;
  localparam logic [SFP_CNT_W-1:0] SFP_LEN_32K  = 12'h280;
  localparam logic [SFP_CNT_W-1:0] SFP_LEN_48K  = 12'h3c0;
  localparam logic [SFP_CNT_W-1:0] SFP_LEN_64K  = 12'h500;
  localparam logic [SFP_CNT_W-1:0] SFP_LEN_MAX  = 12'hfff;

  // ****************************************************************
  // Silence descriptor field positions (frame bit index, MSB first)
  // ****************************************************************
  localparam int SID_TYPE_POS  = 0;
  localparam int FD_BW_POS     = 1;
  localparam int FD_BW_W       = 2;
  localparam int FD_RATE_POS   = 3;
  localparam int FD_GAIN_POS   = 4;
  localparam int FD_GAIN_W     = 7;
  localparam int FD_ENERGY_POS = 11;
  localparam int FD_ENERGY_W   = 37;
  localparam int LP_BW_POS     = 1;
  localparam int LP_RATE_POS   = 2;
  localparam int LP_HANG_POS   = 3;
  localparam int LP_HANG_W     = 3;
  localparam int LP_LSF_POS    = 6;
  localparam int LP_LSF_W      = 29;
  localparam int LP_LOW_POS    = 35;
  localparam int LP_LOW_W      = 7;
  localparam int LP_ENV_POS    = 42;
  localparam int LP_ENV_W      = 6;
  localparam int LP_HB_POS     = 42;
  localparam int LP_HB_W       = 4;

  // ****************************************************************
  // Active frame header positions
  // ****************************************************************
  localparam int CORE_FLAG_POS = 0;
  localparam int CIDX_POS      = 1;
  localparam int CIDX_W        = 4;
  localparam int MDCT_SEL_POS  = 1;
  localparam int TCX_TYPE_POS  = 2;
  localparam int TCX_TYPE_W    = 2;
  localparam int HQ32_PREV_POS = 2;
  localparam int HQ32_RATE_POS = 3;
  localparam int HQ64_PREV_POS = 1;
  localparam int HQ64_RATE_POS = 2;
  localparam int CA_HDR_POS    = 0;
  localparam int CA_HDR_W      = 5;
  localparam int CA_RF_BIT     = 0;

  localparam logic [2:0] CA_OFFSET_0 = 3'h2;
  localparam logic [2:0] CA_OFFSET_1 = 3'h3;
  localparam logic [2:0] CA_OFFSET_2 = 3'h5;
  localparam logic [2:0] CA_OFFSET_3 = 3'h7;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    SFP_RATE_NONE  = 3'h0,
    SFP_RATE_SID   = 3'h1,
    SFP_RATE_13K2  = 3'h2,
    SFP_RATE_CA    = 3'h3,
    SFP_RATE_32K   = 3'h4,
    SFP_RATE_48K   = 3'h5,
    SFP_RATE_64K   = 3'h6
  } sfp_rate_e;

  typedef enum logic [1:0] {
    SFP_CORE_NONE = 2'h0,
    SFP_CORE_LP   = 2'h1,
    SFP_CORE_HQ   = 2'h2,
    SFP_CORE_TCX  = 2'h3
  } sfp_core_e;

  typedef enum logic [2:0] {
    REDUNDANT_TYPE_EMPTY          = 3'h0,
    REDUNDANT_TYPE_TRANSFORM_FREQ = 3'h1,
    REDUNDANT_TYPE_TRANSFORM_TIME_A = 3'h2,
    REDUNDANT_TYPE_TRANSFORM_TIME_B = 3'h3,
    REDUNDANT_TYPE_FULL_PREDICT   = 3'h4,
    REDUNDANT_TYPE_NO_PREDICT     = 3'h5,
    REDUNDANT_TYPE_GENERIC_PREDICT = 3'h6,
    REDUNDANT_TYPE_NOISE_EXCITED  = 3'h7
  } sfp_redundant_e;

endpackage

// ### sfp_parser_monitor.sv
`timescale 1ns/100ps
// ****************
// Output checks
// ****************
module sfp_parser_monitor
  import sfp_pkg::*;
(
  input wire logic                  clk_sys,
  input wire logic                  rst,
  input wire logic                  in_valid,
  input wire logic                  in_last,
  input wire logic                  frame_valid,
  input wire logic                  frame_error,
  input sfp_pkg::sfp_rate_e         frame_rate,
  input wire logic [SFP_CNT_W-1:0]  frame_length,
  input sfp_pkg::sfp_core_e         core_select,
  input wire logic                  hq_prev_lp,
  input wire logic                  hq_rate_16k,
  input wire logic                  sid_is_lp,
  input wire logic [1:0]            audio_bandwidth_index,
  input wire logic [5:0]            sid_envelope,
  input wire logic                  redundant_copy_flag,
  input wire logic [2:0]            ca_offset,
  input sfp_pkg::sfp_redundant_e    ca_type,
  input wire logic                  ca_partial_present
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence last_taken;
    in_valid && in_last;
  endsequence
  sequence result_seen;
    frame_valid || frame_error;
  endsequence

  answer_time_a: assert property (last_taken |=> result_seen)
    else $error("no result one cycle after last bit");
  answer_cause_a: assert property (
    result_seen |-> $past(in_valid && in_last))
    else $error("result without a last bit");
  pulse_once_a: assert property (frame_valid |=> !frame_valid)
    else $error("valid pulse longer than one cycle");
  valid_error_a: assert property (!(frame_valid && frame_error))
    else $error("valid and error together");
  fields_hold_a: assert property (!(in_valid && in_last) |=>
    $stable(frame_rate) && $stable(core_select) && $stable(ca_type))
    else $error("fields changed without a frame end");
  sid_length_a: assert property (
    frame_valid && frame_rate == SFP_RATE_SID
    |-> frame_length == SFP_LEN_SID)
    else $error("silence frame not 48 bits");
  ca_length_a: assert property (
    frame_valid && frame_rate == SFP_RATE_CA
    |-> frame_length == SFP_LEN_13K2 && redundant_copy_flag)
    else $error("redundant frame length or flag wrong");
  ca_offset_a: assert property (
    frame_valid && frame_rate == SFP_RATE_CA
    |-> ca_offset inside {3'h2, 3'h3, 3'h5, 3'h7})
    else $error("offset outside 2 3 5 7");
  partial_flag_a: assert property (
    frame_valid && frame_rate == SFP_RATE_CA
    |-> ca_partial_present == (ca_type != REDUNDANT_TYPE_EMPTY))
    else $error("partial flag disagrees with type");
  core_48k_a: assert property (
    frame_valid && frame_rate == SFP_RATE_48K
    |-> core_select == SFP_CORE_TCX)
    else $error("48k frame not transform core");
  hq_rate_a: assert property (
    frame_valid && !hq_prev_lp |-> !hq_rate_16k)
    else $error("rate bit without previous core");
  swb_envelope_a: assert property (frame_valid && sid_is_lp
    && audio_bandwidth_index[0] |-> sid_envelope == 6'h0)
    else $error("envelope set on super-wide descriptor");
  error_fields_a: assert property (frame_error |->
    frame_rate == SFP_RATE_NONE && core_select == SFP_CORE_NONE)
    else $error("fields not cleared on error");
endmodule // sfp_parser_monitor

bind sfp_frame_parser sfp_parser_monitor mon (.*);

// ### sfp_transport_model.sv
`timescale 1ns/100ps
// ****************
// Serial frame source
// ****************
module sfp_transport_model (
  input  wire logic          clk_sys,
  input  wire logic          go,
  input  wire logic          gap,
  input  wire logic [11:0]   frame_len,
  input  wire logic [0:1279] frame_bits,
  output logic               in_valid,
  output logic               in_bit,
  output logic               in_last,
  output logic               busy
);
  initial begin
    in_valid = 1'b0;
    in_bit = 1'b0;
    in_last = 1'b0;
    busy = 1'b0;
  end

  // One whole frame per request
  // Idle bit is inverted so stale data is never mistaken for a frame bit
  always begin : tx
    int n;
    @(posedge clk_sys iff go === 1'b1);
    busy = 1'b1;
    for (n = 0; n < int'(frame_len); n++) begin
      #1;
      if (gap) begin
        in_valid = 1'b0;
        in_bit = ~in_bit;
        @(posedge clk_sys);
        #1;
      end
      in_valid = 1'b1;
      in_bit = frame_bits[n];
      in_last = (n == int'(frame_len) - 1);
      @(posedge clk_sys);
    end
    #1;
    in_valid = 1'b0;
    in_last = 1'b0;
    in_bit = ~in_bit;
    busy = 1'b0;
  end
endmodule // sfp_transport_model

// ### speech_frame_field_parser_test.sv
`timescale 1ns/100ps
`define CHK(g, e) begin \
  compares++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, g, e); \
  end \
end

module speech_frame_field_parser_test;
  import sfp_pkg::*;
  logic           clk_sys, rst, channel_aware_mode, go, gap, busy;
  logic           in_valid, in_bit, in_last, frame_valid, frame_error;
  logic           hq_prev_lp, hq_rate_16k, sid_is_lp, sid_rate_16k;
  logic           redundant_copy_flag, ca_partial_present;
  logic [11:0]    frame_len, frame_length;
  logic [0:1279]  frame_bits;
  logic [31:0]    seed;
  logic [3:0]     coder_type_index, sid_highband_energy;
  logic [1:0]     transform_excitation_type, audio_bandwidth_index;
  logic [6:0]     sid_gain, sid_lowband_energy;
  logic [36:0]    sid_band_energy;
  logic [2:0]     sid_hangover, ca_offset;
  logic [28:0]    sid_spectral_pairs;
  logic [5:0]     sid_envelope;
  logic [4:0]     ca_header;
  sfp_rate_e      frame_rate;
  sfp_core_e      core_select;
  sfp_redundant_e ca_type;
  int             error_cnt, compares;
  int             lens [8] = '{48, 264, 640, 960, 1280, 47, 264, 100};

  sfp_frame_parser dut (.*);
  sfp_transport_model src (.*);

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // ****************
  // Expected values
  // ****************
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [36:0] fld(input int p, input int w);
    logic [36:0] r;
    r = '0;
    for (int i = 0; i < w; i++)
      r = {r[35:0], frame_bits[p + i]};
    return r;
  endfunction

  function automatic logic [2:0] e_rate(input int n, input logic ca);
    if (ca && n != 264)
      return SFP_RATE_NONE;
    case (n)
      48:      return SFP_RATE_SID;
      264:     return (frame_bits[4] && ca) ? SFP_RATE_CA : SFP_RATE_13K2;
      640:     return SFP_RATE_32K;
      960:     return SFP_RATE_48K;
      1280:    return SFP_RATE_64K;
      default: return SFP_RATE_NONE;
    endcase
  endfunction

  function automatic logic [9:0] e_core(input logic [2:0] r);
    if (r == SFP_RATE_48K)
      return {SFP_CORE_TCX, 8'h0};
    if (r != SFP_RATE_32K && r != SFP_RATE_64K)
      return 10'h0;
    if (!frame_bits[0])
      return {SFP_CORE_LP, 4'(fld(1, 4)), 4'h0};
    if (r == SFP_RATE_64K)
      return {SFP_CORE_HQ, 6'h0, frame_bits[1], &frame_bits[1:2]};
    if (frame_bits[1])
      return {SFP_CORE_TCX, 4'h0, frame_bits[2:3], 2'h0};
    return {SFP_CORE_HQ, 6'h0, frame_bits[2], &frame_bits[2:3]};
  endfunction

  function automatic logic [96:0] e_sid(input logic [2:0] r);
    if (r != SFP_RATE_SID)
      return 97'h0;
    if (!frame_bits[0])
      return {1'b0, 2'(fld(1, 2)), frame_bits[3], 7'(fld(4, 7)),
              fld(11, 37), 49'h0};
    return {1'b1, 1'b0, frame_bits[1:2], 44'h0,
            3'(fld(3, 3)), 29'(fld(6, 29)), 7'(fld(35, 7)),
            frame_bits[1] ? 6'h0 : 6'(fld(42, 6)),
            frame_bits[1] ? 4'(fld(42, 4)) : 4'h0};
  endfunction

  function automatic logic [12:0] e_ca(input logic [2:0] r);
    logic [1:0] c;
    logic [2:0] t;
    c = frame_bits[259:260];
    t = frame_bits[261:263];
    if (r != SFP_RATE_13K2 && r != SFP_RATE_CA)
      return 13'h0;
    if (r == SFP_RATE_13K2)
      return {frame_bits[0:4], 8'h0};
    return {frame_bits[0:4], 1'b1,
            c == 0 ? 3'h2 : c == 1 ? 3'h3 : c == 2 ? 3'h5 : 3'h7,
            t, t != 3'h0};
  endfunction

  // ****************
  // Frame run and verdict
  // ****************
  task automatic run(input int n, input logic ca, input int hd,
                     input int tl, input logic gp);
    logic [2:0]  r;
    logic [96:0] gs;
    int          k;
    for (k = 0; k < 40; k++) begin
      seed = lfsr(seed);
      frame_bits[k*32 +: 32] = seed;
    end
    if (hd >= 0)
      frame_bits[0:4] = hd[4:0];
    if (tl >= 0)
      frame_bits[n-5 +: 5] = tl[4:0];
    @(posedge clk_sys);
    #1;
    channel_aware_mode = ca;
    gap = gp;
    frame_len = 12'(n);
    go = 1'b1;
    @(posedge clk_sys);
    #1;
    go = 1'b0;
    for (k = 0; k < 4000 && busy; k++)
      @(negedge clk_sys);
    r = e_rate(n, ca);
    gs = {sid_is_lp, audio_bandwidth_index, sid_rate_16k, sid_gain,
          sid_band_energy, sid_hangover, sid_spectral_pairs,
          sid_lowband_energy, sid_envelope, sid_highband_energy};
    `CHK(busy, 1'b0)
    `CHK({frame_valid, frame_error}, {r != 3'h0, r == 3'h0})
    `CHK({frame_rate, frame_length}, {r, 12'(n)})
    if (r != SFP_RATE_13K2 && r != SFP_RATE_CA)
      `CHK({core_select, coder_type_index, transform_excitation_type, hq_prev_lp, hq_rate_16k}, e_core(r))
    `CHK(gs, e_sid(r))
    `CHK({ca_header, redundant_copy_flag, ca_offset, ca_type, ca_partial_present}, e_ca(r))
  endtask

  task close_out();
    $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #(8 * 80000);
    error_cnt++;
    close_out();
  end

  initial begin
    rst = 1'b1;
    channel_aware_mode = 1'b0;
    go = 1'b0;
    gap = 1'b0;
    frame_len = 12'h0;
    frame_bits = '0;
    seed = 32'h403ab95f;
    error_cnt = 0;
    compares = 0;
    repeat (6) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    `CHK({frame_valid, frame_error, frame_rate, ca_type}, 8'h0)
    for (int i = 0; i < 8; i++) begin
      run(48, 1'b0, i * 4, -1, 1'b0);
      run(640, 1'b0, i * 4, -1, i[0]);
      run(1280, 1'b0, i * 4, -1, 1'b0);
      run(264, 1'b1, 1, (i % 4) * 8 + i, i[1]);
    end
    run(264, 1'b1, 0, -1, 1'b0);
    run(264, 1'b0, 1, -1, 1'b0);
    run(960, 1'b0, -1, -1, 1'b1);
    run(640, 1'b1, -1, -1, 1'b0);
    run(265, 1'b0, -1, -1, 1'b0);
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      run(lens[seed[2:0]], seed[3], -1, -1, seed[4]);
    end
    close_out();
  end
endmodule // speech_frame_field_parser_test
